// ===== core/asrc_delay_cutoff_control.sv
// ratio tracking, fifo pointer separation, mute and cutoff/tap scaling
`timescale 1ns/1ps
module asrc_delay_cutoff_control
    import asrc_pkg::*;
#(
    parameter int   SETTLE_SLOW_CYC  = SLOW_SETTLE_CYC,
    parameter int   SETTLE_FAST_CYC  = FAST_SETTLE_CYC,
    parameter logic HAS_DELAY_SELECT = 1'b1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         input_frame_clk,
    input  wire logic         output_frame_clk,
    input  wire logic         delay_depth_select,
    input  wire logic         settle_speed_select,
    output logic              mute,
    output logic [6:0]        write_addr,
    output logic [6:0]        read_addr,
    output logic [9:0]        ratio_q,
    output logic [7:0]        tap_count,
    output logic [6:0]        filter_delay,
    output logic [7:0]        total_delay,
    output logic [6:0]        cutoff_code,
    output logic [9:0]        rom_step,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [6:0]        out_addr,
    output logic [9:0]        out_step
);
    // pin resynchroniser: a level counts once stages two and three agree
    logic [3:0]          s1, s2, s3, lv;
    logic [1:0]          rise;
    wire logic [3:0]     pins = {settle_speed_select, delay_depth_select, output_frame_clk, input_frame_clk};
    wire logic [3:0]     next_lv = (s2 & s3) | (lv & (s2 | s3));
    wire logic           in_evt = rise[0];
    wire logic           out_evt = rise[1];
    wire logic           long_mode = HAS_DELAY_SELECT & lv[2];  // R6
    wire logic           slow_mode = lv[3];                      // R20

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            lv <= '0;
            rise <= '0;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            lv <= next_lv;
            rise <= next_lv[1:0] & ~lv[1:0];  // R4
        end
    end

    // per-clock period estimate; both feed the ratio so jitter on either is averaged
    logic [PER_W-1:0]    est_int [2];
    for (genvar i = 0; i < 2; i++) begin : g_per
        logic [PER_W-1:0]              cnt;
        logic [PER_W+FRAC_W-1:0]       est;
        wire logic signed [PER_W+FRAC_W:0] diff =
            $signed({1'b0, cnt, {FRAC_W{1'b0}}}) - $signed({1'b0, est});
        wire logic signed [PER_W+FRAC_W:0] step = slow_mode ? (diff >>> SLOW_SHIFT) : (diff >>> FAST_SHIFT);
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                cnt <= 16'h0001;
                est <= {NOM_PERIOD, {FRAC_W{1'b0}}};
            end else if (rise[i]) begin
                cnt <= 16'h0001;
                est <= est + (PER_W + FRAC_W)'(step);  // R1 R2 R3 R5
            end else if (cnt != '1) begin
                cnt <= cnt + 16'h0001;
            end
        end
        assign est_int[i] = est[PER_W+FRAC_W-1:FRAC_W];
    end
    wire logic [PER_W-1:0] est_in = est_int[0];
    wire logic [PER_W-1:0] est_out = est_int[1];

    // shared serial divider alternates between the rate ratio and the raw cutoff
    div_state_t          div_state;
    logic                div_op;
    logic [31:0]         div_num;
    logic [PER_W:0]      div_rem;
    logic [PER_W-1:0]    div_den;
    logic [5:0]          div_cnt;
    logic [15:0]         cut_raw;
    logic                cut_new;
    wire logic [PER_W:0] div_shift = {div_rem[PER_W-1:0], div_num[31]};
    wire logic           div_ge = div_shift >= {1'b0, div_den};
    wire logic [31:0]    quo = {div_num[30:0], div_ge};
    wire logic [PER_W-1:0] slow_per = (est_in > est_out) ? est_in : est_out;  // R14 R15
    wire logic           next_op = ~div_op;
    wire logic [PER_W-1:0] next_den = next_op ? est_out : slow_per;
    wire logic [31:0]    next_num = next_op ? {8'h00, est_in, 8'h00} : 32'(CUTOFF_NUM);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_state <= DIV_IDLE;
            div_op <= 1'b0;
            div_num <= '0;
            div_rem <= '0;
            div_den <= '0;
            div_cnt <= '0;
            ratio_q <= UNITY_Q;  // R21
            cut_raw <= '0;
            cut_new <= 1'b0;
        end else begin
            cut_new <= 1'b0;
            case (div_state)
                DIV_IDLE: begin
                    div_state <= DIV_RUN;
                    div_op <= next_op;
                    div_num <= next_num;
                    div_den <= (next_den == '0) ? 16'h0001 : next_den;
                    div_rem <= '0;
                    div_cnt <= '0;
                end
                DIV_RUN: begin
                    div_rem <= div_ge ? div_shift - {1'b0, div_den} : div_shift;
                    div_num <= quo;
                    div_cnt <= div_cnt + 6'h01;
                    if (div_cnt == DIV_LAST) begin
                        div_state <= DIV_IDLE;
                        if (div_op) begin
                            ratio_q <= (quo > 32'(Q_MAX)) ? Q_MAX : quo[9:0];
                        end else begin
                            cut_raw <= (quo > 32'h0000ffff) ? 16'hffff : quo[15:0];
                            cut_new <= 1'b1;
                        end
                    end
                end
                default: div_state <= DIV_IDLE;
            endcase
        end
    end

    // tap count and coefficient step from the ratio; even counts keep the filter symmetric
    wire logic           down = ratio_q < UNITY_Q;
    wire logic [9:0]     q_c = (ratio_q < HALF_Q) ? HALF_Q : ratio_q;
    wire logic [9:0]     q_gap = UNITY_Q - q_c;
    wire logic [7:0]     next_taps = down ? BASE_TAPS + {q_gap[8:2], 1'b0} : BASE_TAPS;  // R9 R10 R18
    wire logic [9:0]     next_step = down ? q_c : UNITY_Q;  // R13

    // cutoff smoothing, then grid selection with one grid step of dead band
    logic [PER_W+SMOOTH_SHIFT-1:0] smooth;
    wire logic signed [PER_W+SMOOTH_SHIFT:0] sm_diff =
        $signed({1'b0, cut_raw, {SMOOTH_SHIFT{1'b0}}}) - $signed({1'b0, smooth});
    wire logic [16:0]    code_hz = 17'(cutoff_code) * GRID_HZ;
    wire logic [16:0]    sm_hz = {1'b0, smooth[PER_W+SMOOTH_SHIFT-1:SMOOTH_SHIFT]};
    wire logic           code_up = (sm_hz >= code_hz + GRID_HZ + GRID_HZ) && (cutoff_code != '1);
    wire logic           code_dn = (sm_hz < code_hz) && (cutoff_code != '0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            smooth <= '0;
            cutoff_code <= '0;
            tap_count <= BASE_TAPS;
            filter_delay <= BASE_TAPS[7:1];
            rom_step <= UNITY_Q;
        end else begin
            if (cut_new) begin
                smooth <= smooth + (PER_W + SMOOTH_SHIFT)'(sm_diff >>> SMOOTH_SHIFT);  // R16
            end
            if (code_up) begin
                cutoff_code <= cutoff_code + 7'h01;  // R17
            end else if (code_dn) begin
                cutoff_code <= cutoff_code - 7'h01;  // R17
            end
            tap_count <= next_taps;
            filter_delay <= next_taps[7:1];  // R23
            rom_step <= next_step;
        end
    end

    // fifo pointers: writer follows input frames, reader advances per output word
    logic                hold, cross_mute, out_pend, tail_v;
    wire logic [6:0]     target = long_mode ? LONG_SEP : SHORT_SEP;  // R7 R8 R12
    wire logic [6:0]     sep = write_addr - read_addr;
    wire logic           push = out_pend && !tail_v;
    wire logic           underflow = push && !hold && (sep <= 7'h01);
    wire logic           overflow = in_evt && (sep == FIFO_TOP);
    wire logic           adv = push && !hold && !underflow;
    wire logic           regained = sep >= target;
    wire logic [6:0]     next_wr = write_addr + {6'h00, in_evt};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_addr <= '0;
            read_addr <= '0;
            hold <= 1'b1;
            cross_mute <= 1'b1;
            out_pend <= 1'b0;
        end else begin
            write_addr <= next_wr;  // R19
            if (overflow) begin
                read_addr <= next_wr - target;  // R7 R8
            end else if (adv) begin
                read_addr <= read_addr + 7'h01;
            end
            hold <= underflow | (hold & ~regained);  // R22
            cross_mute <= underflow | overflow | (cross_mute & ~regained);  // R11 R22
            out_pend <= out_evt | (out_pend & ~push);
        end
    end

    // startup mute: at least the minimum and for the settle time of the chosen speed
    logic [SETTLE_W-1:0] settle_cnt;
    wire logic [SETTLE_W-1:0] settle_need = slow_mode ? SETTLE_W'(SETTLE_SLOW_CYC) : SETTLE_W'(SETTLE_FAST_CYC);
    wire logic           startup = (settle_cnt < settle_need) || (settle_cnt < SETTLE_W'(MIN_MUTE_CYC));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_cnt <= '0;
            mute <= 1'b1;
            total_delay <= '0;
        end else begin
            if (startup) begin
                settle_cnt <= settle_cnt + 1'b1;
            end
            mute <= startup | cross_mute;  // R11 R21
            total_delay <= {1'b0, target} + {1'b0, filter_delay};  // R23
        end
    end

    // two-entry buffer: head drives the ports, tail absorbs one word while stalled
    logic [6:0]          tail_addr;
    logic [9:0]          tail_step;
    wire logic           pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tail_v <= 1'b0;
            tail_addr <= '0;
            tail_step <= '0;
            out_valid <= 1'b0;
            out_addr <= '0;
            out_step <= '0;
        end else if (tail_v) begin
            if (pop) begin
                out_addr <= tail_addr;
                out_step <= tail_step;
                tail_v <= 1'b0;
            end
        end else if (push) begin
            if (!out_valid || pop) begin
                out_addr <= read_addr;
                out_step <= rom_step;
                out_valid <= 1'b1;
            end else begin
                tail_addr <= read_addr;
                tail_step <= rom_step;
                tail_v <= 1'b1;
            end
        end else if (pop) begin
            out_valid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_sync_agree:   assert property (rise[0] |-> $past(s2[0]) && $past(s3[0]))  // R4
        else $error("input frame edge taken before two stages agreed");
    a_write_count:  assert property (in_evt |=> write_addr == $past(write_addr) + 7'h01)  // R19
        else $error("write address did not follow input frame");
    a_sep_release:  assert property ($fell(hold) |-> $past(sep) >= ($past(long_mode) ? LONG_SEP : SHORT_SEP))  // R7
        else $error("reader released short of the separation");
    a_cross_mute:   assert property ((underflow || overflow) |-> ##2 mute)  // R11
        else $error("pointer crossing did not raise mute");
    a_reset_mute:   assert property ((settle_cnt < SETTLE_W'(MIN_MUTE_CYC)) |=> mute)  // R21
        else $error("mute dropped inside the startup window");
    a_upsample_tap: assert property (!down |=> tap_count == BASE_TAPS && filter_delay == 7'h20)  // R9
        else $error("upsampling tap count not 64");
    a_tap_range:    assert property (tap_count >= BASE_TAPS && tap_count <= MAX_TAPS && !tap_count[0])  // R10
        else $error("tap count out of range or odd");
    a_rom_scale:    assert property (down |=> rom_step == $past(q_c) && rom_step < UNITY_Q)  // R13
        else $error("coefficient step not scaled while downsampling");
    a_code_step:    assert property ($changed(cutoff_code) |->
                        (cutoff_code == $past(cutoff_code) + 7'h01) || (cutoff_code == $past(cutoff_code) - 7'h01))  // R17
        else $error("cutoff code moved more than one grid step");
    a_buf_hold:     assert property (out_valid && !out_ready |=> out_valid && $stable(out_addr) && $stable(out_step))
        else $error("buffered word changed while stalled");

    c_underflow:    cover property (underflow);
    c_overflow:     cover property (overflow);
    c_downsample:   cover property (down && tap_count > BASE_TAPS);
    c_buffer_full:  cover property (tail_v && out_evt);
endmodule

// ===== core/asrc_pkg.sv
// constants and types for the sample rate converter control core
// How it works
// R1: slow mode corner near 3 Hz, 800 ms
// R2: fast mode corner near 12 Hz, 200 ms
// R3: ratio averages both input and output periods
// R4: frame clocks resynchronised before the loop
// R5: single-pole averaging gives 6 dB/octave
// R6: depth select picks separation; variant forces short
// R7: short mode keeps five locations apart
// R8: long mode keeps 96 locations apart
// R9: upsampling uses 64 taps
// R10: downsampling taps grow linearly to 128
// R11: pointer crossing raises mute
// R12: long plus fast absorbs 2:1 step
// R13: downsampling scales coefficient step by ratio
// R14: downsampling cutoff follows output rate
// R15: upsampling cutoff follows input rate
// R16: cutoff smoothed by single-pole filter
// R17: cutoff code on 300 Hz grid, hysteresis
// R18: tap counts stay even, linear phase
// R19: write address counts input frames
// R20: settle speed change adopted on the fly
// R21: reset gives 1:1, mute 128+ cycles
// R22: mute holds until separation regained
// R23: filter delay is half the tap count
package asrc_pkg;
    localparam int              CLK_HZ          = 50_000_000;
    localparam int              SLOW_SETTLE_MS  = 800;
    localparam int              FAST_SETTLE_MS  = 200;
    localparam int              SLOW_SETTLE_CYC = SLOW_SETTLE_MS * (CLK_HZ / 1000);
    localparam int              FAST_SETTLE_CYC = FAST_SETTLE_MS * (CLK_HZ / 1000);
    localparam int              SETTLE_W        = 26;
    localparam int              MIN_MUTE_CYC    = 128;
    localparam int              SLOW_SHIFT      = 11;      // about 3 Hz corner at 48 kHz frames
    localparam int              FAST_SHIFT      = 9;       // four times wider corner
    localparam int              PER_W           = 16;
    localparam int              FRAC_W          = 12;
    localparam logic [15:0]     NOM_PERIOD      = 16'h0411;
    localparam logic [6:0]      SHORT_SEP       = 7'h05;
    localparam logic [6:0]      LONG_SEP        = 7'h60;
    localparam logic [6:0]      FIFO_TOP        = 7'h7f;
    localparam logic [9:0]      UNITY_Q         = 10'h100;
    localparam logic [9:0]      HALF_Q          = 10'h080;
    localparam logic [9:0]      Q_MAX           = 10'h3ff;
    localparam logic [7:0]      BASE_TAPS       = 8'h40;
    localparam logic [7:0]      MAX_TAPS        = 8'h80;
    localparam int              CUTOFF_NUM      = int'(64'(CLK_HZ) * 64'd20000 / 64'd44100);
    localparam logic [16:0]     GRID_HZ         = 17'h0012c;
    localparam int              SMOOTH_SHIFT    = 4;
    localparam logic [5:0]      DIV_LAST        = 6'h1f;
    typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;
endpackage

// ===== dv/audio_port_model.sv
// serial audio source and sink seen from the converter core: frame clocks and a word sink
`timescale 1ns/1ps
module audio_port_model (
    input  wire logic       clk,
    input  wire logic       in_run,
    input  wire logic       out_run,
    input  wire logic [7:0] in_half,
    input  wire logic [7:0] out_half,
    input  wire logic       stall,
    output logic            input_frame_clk,
    output logic            output_frame_clk,
    output logic            out_ready
);
    logic [7:0] in_cnt  = 8'h00;
    logic [7:0] out_cnt = 8'h00;

    initial begin
        input_frame_clk  = 1'b0;
        output_frame_clk = 1'b0;
    end

    // a stopped source parks its frame clock low; halves are whole clk counts, so edges stay clean
    always @(posedge clk) begin
        if (!in_run) begin
            in_cnt          <= #1 8'h00;
            input_frame_clk <= #1 1'b0;
        end else if (in_cnt + 8'h01 >= in_half) begin
            in_cnt          <= #1 8'h00;
            input_frame_clk <= #1 ~input_frame_clk;
        end else begin
            in_cnt <= #1 in_cnt + 8'h01;
        end
    end

    // output side frame clock, independent rate so ratios other than 1:1 can be made
    always @(posedge clk) begin
        if (!out_run) begin
            out_cnt          <= #1 8'h00;
            output_frame_clk <= #1 1'b0;
        end else if (out_cnt + 8'h01 >= out_half) begin
            out_cnt          <= #1 8'h00;
            output_frame_clk <= #1 ~output_frame_clk;
        end else begin
            out_cnt <= #1 out_cnt + 8'h01;
        end
    end

    // sink refuses words while stalled; no buffering of its own
    assign out_ready = ~stall;
endmodule

// ===== dv/tb.sv
// self-checking bench for the converter control core
`timescale 1ns/1ps
`define cmp(name, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", name, exp, got); end end
module tb
    import asrc_pkg::*;
;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       delay_depth_select = 1'b0;
    logic       settle_speed_select = 1'b0;
    logic       in_run = 1'b0;
    logic       out_run = 1'b0;
    logic [7:0] in_half = 8'h06;
    logic [7:0] out_half = 8'h06;
    logic       stall = 1'b0;
    logic       input_frame_clk, output_frame_clk, out_ready, mute, out_valid;
    logic [6:0] write_addr, read_addr, filter_delay, cutoff_code, out_addr, sep, snap_a, snap_r;
    logic [9:0] ratio_q, rom_step, out_step;
    logic [7:0] tap_count, total_delay;
    int         n_errors = 0;
    int         checked = 0;

    assign sep = write_addr - read_addr;

    initial begin
        forever #10 clk = ~clk;
    end

    audio_port_model partner (.clk(clk), .in_run(in_run), .out_run(out_run), .in_half(in_half),
        .out_half(out_half), .stall(stall), .input_frame_clk(input_frame_clk),
        .output_frame_clk(output_frame_clk), .out_ready(out_ready));

    // settle counts shortened; both stay above the 128-cycle mute floor
    asrc_delay_cutoff_control #(.SETTLE_SLOW_CYC(300), .SETTLE_FAST_CYC(150), .HAS_DELAY_SELECT(1'b1)) dut (
        .clk(clk), .arst_n(arst_n), .input_frame_clk(input_frame_clk), .output_frame_clk(output_frame_clk),
        .delay_depth_select(delay_depth_select), .settle_speed_select(settle_speed_select), .mute(mute),
        .write_addr(write_addr), .read_addr(read_addr), .ratio_q(ratio_q), .tap_count(tap_count),
        .filter_delay(filter_delay), .total_delay(total_delay), .cutoff_code(cutoff_code),
        .rom_step(rom_step), .out_valid(out_valid), .out_ready(out_ready), .out_addr(out_addr),
        .out_step(out_step));

    task automatic complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // inputs change 1 ns after the edge, outputs are read there too
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_mute(input logic level, input int bound);
        for (int i = 0; i < bound && mute !== level; i++) step(1);
        if (mute !== level) begin
            n_errors++;
            $display("mismatch mute_wait expected %h seen %h", level, mute);
            complete_run();
        end
    endtask

    // reset with frame clocks running from release; checks reset state and the mute floor
    task automatic start(input logic depth, input logic slow, input int hold_chk);
        arst_n = 1'b0;
        in_run = 1'b0;
        out_run = 1'b0;
        delay_depth_select = depth;
        settle_speed_select = slow;
        step(4);
        `cmp("mute_rst", 1'b1, mute)
        `cmp("ratio_rst", UNITY_Q, ratio_q)
        `cmp("taps_rst", BASE_TAPS, tap_count)
        `cmp("fdelay_rst", 7'h20, filter_delay)
        `cmp("wptr_rst", 7'h00, write_addr)
        `cmp("valid_rst", 1'b0, out_valid)
        arst_n = 1'b1;
        in_run = 1'b1;
        out_run = 1'b1;
        step(127);
        `cmp("mute_min", 1'b1, mute)
        step(hold_chk - 127);
        `cmp("mute_settle", 1'b1, mute)
    endtask

    // short mode, fast loop, equal rates
    task automatic t_short_fast();
        start(1'b0, 1'b0, 140);
        wait_mute(1'b0, 400);
        `cmp("sep_short", 1'b1, (sep >= SHORT_SEP && sep <= SHORT_SEP + 7'h01))
        `cmp("total_short", 8'h25, total_delay)
        `cmp("taps_unity", BASE_TAPS, tap_count)
        `cmp("cutoff_moved", 1'b1, (cutoff_code != 7'h00))
    endtask

    // long mode, slow loop; the slow setting is also changed on the fly
    task automatic t_long_slow();
        start(1'b1, 1'b1, 290);
        wait_mute(1'b0, 3000);
        `cmp("sep_long", 1'b1, (sep >= LONG_SEP && sep <= LONG_SEP + 7'h01))
        `cmp("total_long", 8'h80, total_delay)
        settle_speed_select = 1'b0;
        step(300);
        `cmp("mute_on_fly", 1'b0, mute)
    endtask

    // receiver stall: the buffered word must stand and the reader must not advance
    task automatic t_stall();
        stall = 1'b1;
        step(60);
        snap_a = out_addr;
        snap_r = read_addr;
        step(24);
        `cmp("valid_stall", 1'b1, out_valid)
        `cmp("addr_stall", snap_a, out_addr)
        `cmp("rptr_stall", snap_r, read_addr)
        `cmp("ostep_stall", 1'b1, (out_step >= 10'h0f0 && out_step <= UNITY_Q))
        stall = 1'b0;
        step(100);
        `cmp("mute_stall", 1'b0, mute)
    endtask

    // input source stops: reader runs into writer, then recovers when input resumes
    task automatic t_underflow();
        in_run = 1'b0;
        wait_mute(1'b1, 300);
        in_run = 1'b1;
        wait_mute(1'b0, 600);
        `cmp("sep_regain", 1'b1, (sep >= SHORT_SEP && sep <= SHORT_SEP + 7'h01))
    endtask

    // output at half the input rate: taps grow, rom step shrinks, delay tracks taps
    task automatic t_downsample();
        out_half = 8'h0c;
        start(1'b0, 1'b0, 140);
        step(6000);
        `cmp("ratio_down", 1'b1, (ratio_q < UNITY_Q))
        `cmp("taps_down", 1'b1, (tap_count > BASE_TAPS && tap_count <= MAX_TAPS))
        `cmp("taps_even", 1'b0, tap_count[0])
        `cmp("fdelay_down", tap_count[7:1], filter_delay)
        `cmp("step_down", 1'b1, (rom_step < UNITY_Q))
    endtask

    initial begin
        t_short_fast();
        t_stall();
        t_underflow();
        t_long_slow();
        t_downsample();
        complete_run();
    end
endmodule
